// *** rtl/cis_consts.svh ***
// Offsets, field positions, reset values and timing counts of the interrupt sequencer.
// Assumes inclusion by bare name from the package and the design file.
`ifndef CIS_CONSTS_SVH
`define CIS_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses on the register bus)
`define CIS_OFF_STATUS   8'h00
`define CIS_OFF_ENABLE   8'h04
`define CIS_OFF_FLAGS    8'h08
`define CIS_OFF_LEVELSEL 8'h0c
`define CIS_OFF_STACKPTR 8'h10
`define CIS_OFF_STATE    8'h14

// ==========================================================================
// Field positions and reset values
`define CIS_GIE_BIT      3'd7
`define CIS_SRC_N        8
`define CIS_PC_W         12
`define CIS_SP_RESET     16'h025f
`define CIS_STATUS_RESET 8'h00

// ==========================================================================
// Timing counts in clock cycles
`define CIS_ENTRY_CYC    2'd3
`define CIS_WAKE_CYC     2'd3
`define CIS_RET_CYC      2'd3

// ==========================================================================
// Bus answers
`define CIS_RESP_OKAY    2'b00
`define CIS_RESP_SLVERR  2'b10

`endif

// *** rtl/cis_pkg.sv ***
// Types shared by the interrupt sequencer and its surroundings.
// Assumes cis_consts.svh is on the include path.
`include "cis_consts.svh"

package cis_pkg;
	typedef logic [`CIS_PC_W-1:0] cis_pc_type;
	typedef logic [`CIS_SRC_N-1:0] cis_src_type;

	typedef enum {S_RUN, S_WAKE, S_PUSH, S_POP} cis_state_type;

	// One cycle view of the pipeline at an instruction boundary
	typedef struct packed {
		logic       instrDone;
		logic       cliExec;
		logic       seiExec;
		logic       retExec;
		logic       sleeping;
		cis_pc_type nextPc;
	} cis_cpu_in_type;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cis_stack_type;
endpackage : cis_pkg

// *** rtl/cis_sequencer.sv ***
// Reset and interrupt sequencer of a small 8-bit core, with AXI4-Lite registers.
// Assumes one clock, a pipeline that reports instruction boundaries, and a
// stack memory whose read data follows its address by one cycle.
//
// Contract
// - Take a source only when its enable and global enable are both one.
// - Vectors sit lowest; lower vector wins, reset first, external request zero next.
// - Accepting any interrupt clears global enable.
// - Global enable set inside a handler lets enabled interrupts nest.
// - Return from handler sets global enable.
// - Vectoring clears the pending flag of a flag-type source.
// - Writing one to a flag clears it; zero does nothing.
// - Flags set while the source is disabled stay until enabled or cleared.
// - Flags wait while global enable is off, then run in priority order.
// - Level sources request only while present; vanished conditions cause nothing.
// - After return, one instruction runs before any pending interrupt.
// - Status register is neither saved on entry nor restored on return.
// - Disable instruction acts at once, even against a simultaneous request.
// - After the enable instruction, the next instruction runs first.
// - Entry takes four cycles pushing the program counter, then the vector.
// - Requests wait until a multi-cycle instruction has completed.
// - Waking from sleep adds four cycles to the response.
// - Return takes four cycles: pops two bytes, stack pointer plus two, sets enable.
// - Program counter addresses 16-bit words; twelve bits here.
// - Entry lowers the stack pointer by two; stack grows downward.
`timescale 1ns/10ps
`include "cis_consts.svh"

module cis_sequencer (
	input  wire logic                   sys_clk,
	input  wire logic                   reset_n,
	input  wire logic                   clkEn,
	input  wire cis_pkg::cis_cpu_in_type cpuIn,
	input  wire cis_pkg::cis_src_type    srcEvent,
	input  wire cis_pkg::cis_src_type    srcLevel,
	input  wire logic [7:0]             stackRdata,
	output logic                        busy_r,
	output logic                        resumeValid_r,
	output cis_pkg::cis_pc_type         resumePc_r,
	output cis_pkg::cis_stack_type      stack_r,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	import cis_pkg::*;

	// ======================================================================
	// State
	cis_state_type state_r, state_nxt;
	logic [1:0]    cnt_r, cnt_nxt;
	logic [7:0]    status_r, status_nxt;
	cis_src_type   enable_r, enable_nxt;
	cis_src_type   flags_r, flags_nxt;
	cis_src_type   levelSel_r, levelSel_nxt;
	logic [15:0]   sp_r, sp_nxt;
	cis_pc_type    savedPc_r, savedPc_nxt;
	logic [2:0]    win_r, win_nxt;
	logic [7:0]    popHigh_r, popHigh_nxt;
	logic          blockOne_r, blockOne_nxt;
	logic          busy_nxt, resumeValid_nxt;
	cis_pc_type    resumePc_nxt;
	cis_stack_type stack_nxt;
	logic          awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
	logic [7:0]    awAddr_r, awAddr_nxt;
	logic [31:0]   wData_r, wData_nxt;
	logic [3:0]    wStrb_r, wStrb_nxt;
	logic          awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]    bresp_nxt, rresp_nxt;
	logic [31:0]   rdata_nxt;
	cis_src_type   request, swClr, hwClr;
	logic          takeNow, retNow;

	// ======================================================================
	// Functions
	// Lowest index wins; index zero belongs to reset and never requests
	function automatic logic [2:0] cis_prio(input cis_src_type req);
		logic [2:0] idx;
		idx = 3'd0;
		for (int i = `CIS_SRC_N - 1; i >= 1; i--) begin
			if (req[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : cis_prio

	function automatic logic cis_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr == off;
	endfunction : cis_hit

	function automatic logic [31:0] cis_read(input logic [7:0] addr, input logic [7:0] st,
		input cis_src_type en, input cis_src_type fl, input cis_src_type lv,
		input logic [15:0] sp, input cis_state_type sq);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (cis_hit(addr, `CIS_OFF_STATUS)) d = {24'h00_0000, st};
		if (cis_hit(addr, `CIS_OFF_ENABLE)) d = {24'h00_0000, en};
		if (cis_hit(addr, `CIS_OFF_FLAGS)) d = {24'h00_0000, fl};
		if (cis_hit(addr, `CIS_OFF_LEVELSEL)) d = {24'h00_0000, lv};
		if (cis_hit(addr, `CIS_OFF_STACKPTR)) d = {16'h0000, sp};
		if (cis_hit(addr, `CIS_OFF_STATE)) d = {30'h0000_0000, 2'(sq)};
		return d;
	endfunction : cis_read

	function automatic logic cis_mapped(input logic [7:0] addr);
		return cis_hit(addr, `CIS_OFF_STATUS) || cis_hit(addr, `CIS_OFF_ENABLE) ||
			cis_hit(addr, `CIS_OFF_FLAGS) || cis_hit(addr, `CIS_OFF_LEVELSEL) ||
			cis_hit(addr, `CIS_OFF_STACKPTR) || cis_hit(addr, `CIS_OFF_STATE);
	endfunction : cis_mapped

	// ======================================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		status_nxt = status_r;
		enable_nxt = enable_r;
		levelSel_nxt = levelSel_r;
		sp_nxt = sp_r;
		savedPc_nxt = savedPc_r;
		win_nxt = win_r;
		popHigh_nxt = popHigh_r;
		blockOne_nxt = blockOne_r;
		busy_nxt = busy_r;
		resumeValid_nxt = 1'b0;
		resumePc_nxt = resumePc_r;
		stack_nxt = stack_r;
		stack_nxt.we = 1'b0;
		awHeld_nxt = awHeld_r;
		awAddr_nxt = awAddr_r;
		wHeld_nxt = wHeld_r;
		wData_nxt = wData_r;
		wStrb_nxt = wStrb_r;
		bvalid_nxt = s_axi_bvalid;
		bresp_nxt = s_axi_bresp;
		rvalid_nxt = s_axi_rvalid;
		rresp_nxt = s_axi_rresp;
		rdata_nxt = s_axi_rdata;
		swClr = '0;
		hwClr = '0;
		takeNow = 1'b0;
		retNow = 1'b0;

		// Register bus: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_nxt = 1'b1;
			awAddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_nxt = 1'b1;
			wData_nxt = s_axi_wdata;
			wStrb_nxt = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (awHeld_r && wHeld_r && !s_axi_bvalid) begin
			awHeld_nxt = 1'b0;
			wHeld_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = cis_mapped(awAddr_r) ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
			if (wStrb_r[0]) begin
				if (cis_hit(awAddr_r, `CIS_OFF_STATUS)) status_nxt = wData_r[7:0];
				if (cis_hit(awAddr_r, `CIS_OFF_ENABLE)) enable_nxt = wData_r[7:0];
				if (cis_hit(awAddr_r, `CIS_OFF_FLAGS)) swClr = wData_r[7:0];
				if (cis_hit(awAddr_r, `CIS_OFF_LEVELSEL)) levelSel_nxt = wData_r[7:0];
				if (cis_hit(awAddr_r, `CIS_OFF_STACKPTR)) sp_nxt[7:0] = wData_r[7:0];
			end
			if (wStrb_r[1] && cis_hit(awAddr_r, `CIS_OFF_STACKPTR)) begin
				sp_nxt[15:8] = wData_r[15:8];
			end
		end
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = cis_mapped(s_axi_araddr) ? `CIS_RESP_OKAY : `CIS_RESP_SLVERR;
			rdata_nxt = cis_read(s_axi_araddr, status_r, enable_r, flags_r, levelSel_r,
				sp_r, state_r);
		end
		awready_nxt = !awHeld_nxt && !bvalid_nxt;
		wready_nxt = !wHeld_nxt && !bvalid_nxt;
		arready_nxt = !rvalid_nxt;

		// Flag sources pend on their flag, level sources only while present
		request = ((flags_r & ~levelSel_r) | (srcLevel & levelSel_r)) & enable_r;
		request[0] = 1'b0;

		// Sequencer; hardware actions follow software writes and win over them
		unique case (state_r)
			S_RUN: begin
				if (cpuIn.instrDone) begin
					blockOne_nxt = 1'b0;
					if (cpuIn.cliExec) begin
						status_nxt[`CIS_GIE_BIT] = 1'b0;
					end else if (cpuIn.seiExec) begin
						status_nxt[`CIS_GIE_BIT] = 1'b1;
						blockOne_nxt = 1'b1;
					end else if (cpuIn.retExec) begin
						retNow = 1'b1;
						state_nxt = S_POP;
						cnt_nxt = 2'd0;
						busy_nxt = 1'b1;
					end else if (status_r[`CIS_GIE_BIT] && !blockOne_r && request != '0) begin
						takeNow = 1'b1;
						win_nxt = cis_prio(request);
						hwClr[cis_prio(request)] = !levelSel_r[cis_prio(request)];
						status_nxt[`CIS_GIE_BIT] = 1'b0;
						savedPc_nxt = cpuIn.nextPc;
						busy_nxt = 1'b1;
						cnt_nxt = 2'd0;
						state_nxt = cpuIn.sleeping ? S_WAKE : S_PUSH;
					end
				end
			end
			S_WAKE: begin
				cnt_nxt = cnt_r + 2'd1;
				if (cnt_r == `CIS_WAKE_CYC) begin
					state_nxt = S_PUSH;
					cnt_nxt = 2'd0;
				end
			end
			S_PUSH: begin
				cnt_nxt = cnt_r + 2'd1;
				if (cnt_r == 2'd0 || cnt_r == 2'd1) begin
					stack_nxt.we = 1'b1;
					stack_nxt.addr = sp_r;
					stack_nxt.wdata = (cnt_r == 2'd0) ? savedPc_r[7:0] :
						{4'h0, savedPc_r[`CIS_PC_W-1:8]};
					sp_nxt = sp_r - 16'h0001;
				end
				if (cnt_r == `CIS_ENTRY_CYC) begin
					state_nxt = S_RUN;
					busy_nxt = 1'b0;
					resumeValid_nxt = 1'b1;
					resumePc_nxt = cis_pc_type'(win_r);
				end
			end
			S_POP: begin
				cnt_nxt = cnt_r + 2'd1;
				// Stack data lags the address by a cycle
				if (cnt_r == 2'd0) stack_nxt.addr = sp_r + 16'h0001;
				if (cnt_r == 2'd1) begin
					stack_nxt.addr = sp_r + 16'h0002;
				end
				if (cnt_r == `CIS_RET_CYC - 2'd1) begin
					popHigh_nxt = stackRdata;
				end
				if (cnt_r == `CIS_RET_CYC) begin
					resumePc_nxt = cis_pc_type'({popHigh_r, stackRdata});
					sp_nxt = sp_r + 16'h0002;
					status_nxt[`CIS_GIE_BIT] = 1'b1;
					blockOne_nxt = 1'b1;
					state_nxt = S_RUN;
					busy_nxt = 1'b0;
					resumeValid_nxt = 1'b1;
				end
			end
		endcase

		// A new event wins over either clear in the same cycle
		flags_nxt = (flags_r & ~swClr & ~hwClr) | (srcEvent & ~levelSel_r);
	end

	// ======================================================================
	// Registers; clkEn low freezes everything
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= S_RUN;
			cnt_r <= 2'd0;
			status_r <= `CIS_STATUS_RESET;
			enable_r <= '0;
			flags_r <= '0;
			levelSel_r <= '0;
			sp_r <= `CIS_SP_RESET;
			savedPc_r <= '0;
			win_r <= 3'd0;
			popHigh_r <= 8'h00;
			blockOne_r <= 1'b0;
			busy_r <= 1'b0;
			resumeValid_r <= 1'b0;
			resumePc_r <= '0;
			stack_r <= '0;
			awHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wHeld_r <= 1'b0;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h0000_0000;
		end else if (clkEn) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			status_r <= status_nxt;
			enable_r <= enable_nxt;
			flags_r <= flags_nxt;
			levelSel_r <= levelSel_nxt;
			sp_r <= sp_nxt;
			savedPc_r <= savedPc_nxt;
			win_r <= win_nxt;
			popHigh_r <= popHigh_nxt;
			blockOne_r <= blockOne_nxt;
			busy_r <= busy_nxt;
			resumeValid_r <= resumeValid_nxt;
			resumePc_r <= resumePc_nxt;
			stack_r <= stack_nxt;
			awHeld_r <= awHeld_nxt;
			awAddr_r <= awAddr_nxt;
			wHeld_r <= wHeld_nxt;
			wData_r <= wData_nxt;
			wStrb_r <= wStrb_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready <= wready_nxt;
			s_axi_bvalid <= bvalid_nxt;
			s_axi_bresp <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid <= rvalid_nxt;
			s_axi_rresp <= rresp_nxt;
			s_axi_rdata <= rdata_nxt;
		end
	end

	// ======================================================================
	// Assertions
	default clocking cb @(posedge sys_clk iff clkEn);
	endclocking
	default disable iff (!reset_n);

	sequence s_entry;
		(state_r == S_PUSH)[*4] ##1 (resumeValid_r && !busy_r);
	endsequence

	sequence s_wake;
		(state_r == S_WAKE)[*4];
	endsequence

	property p_gate;
		takeNow |-> status_r[`CIS_GIE_BIT] && (enable_r[win_nxt] == 1'b1);
	endproperty
	a_gate: assert property (p_gate) else $error("Source taken while not enabled");

	property p_clear_gie;
		takeNow |=> !status_r[`CIS_GIE_BIT];
	endproperty
	a_clear_gie: assert property (p_clear_gie) else $error("Enable left set on entry");

	property p_entry;
		takeNow && !cpuIn.sleeping |=> s_entry ##0 (resumePc_r == cis_pc_type'(win_r));
	endproperty
	a_entry: assert property (p_entry) else $error("Entry not four cycles to vector");

	property p_wake;
		takeNow && cpuIn.sleeping |=> s_wake ##1 s_entry;
	endproperty
	a_wake: assert property (p_wake) else $error("Wake penalty not four cycles");

	property p_return;
		retNow |-> ##5 (resumeValid_r && status_r[`CIS_GIE_BIT] && sp_r == $past(sp_r, 5) + 16'h0002);
	endproperty
	a_return: assert property (p_return) else $error("Return sequence wrong");

	property p_cli;
		cpuIn.instrDone && cpuIn.cliExec && state_r == S_RUN |-> !takeNow ##1 !status_r[`CIS_GIE_BIT];
	endproperty
	a_cli: assert property (p_cli) else $error("Interrupt taken with disable");

	property p_one_instr;
		resumeValid_r && $past(state_r) == S_POP |-> blockOne_r && !takeNow;
	endproperty
	a_one_instr: assert property (p_one_instr) else $error("No instruction after return");

	property p_flag_clr;
		takeNow && !levelSel_r[win_nxt] && !srcEvent[win_nxt] |=> !flags_r[win_r];
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("Flag not cleared on vectoring");

	property p_push;
		takeNow |-> ##[1:5] stack_nxt.we ##1 stack_r.we ##2 (sp_r == $past(sp_r, 3) - 16'h0002);
	endproperty
	a_push: assert property (p_push) else $error("Stack pointer not lowered by two");
endmodule : cis_sequencer

// *** tb/cis_periph_model.sv ***
// Stand-in for the peripherals: turns bench commands into flag pulses and levels.
// Assumes the bench changes its commands just after a rising clock edge.
`timescale 1ns/10ps

module cis_periph_model (
	input  wire logic                sys_clk,
	input  wire logic                reset_n,
	input  wire cis_pkg::cis_src_type fireCmd,
	input  wire cis_pkg::cis_src_type levelCmd,
	output cis_pkg::cis_src_type      srcEvent,
	output cis_pkg::cis_src_type      srcLevel
);
	import cis_pkg::*;

	cis_src_type fireD_r;

	// ==========================================================================
	// Event and level drive
	// A held command yields one pulse only, as a real event would
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			fireD_r  <= '0;
			srcEvent <= '0;
			srcLevel <= '0;
		end else begin
			fireD_r  <= fireCmd;
			srcEvent <= fireCmd & ~fireD_r;
			srcLevel <= levelCmd;
		end
	end
endmodule : cis_periph_model

// *** tb/cis_sequencer_tb.sv ***
// Self-checking bench of the interrupt sequencer: bus tasks, stack memory, queued checks.
// Assumes the design files and the peripheral model are compiled first.
`timescale 1ns/10ps
`include "cis_consts.svh"

module cis_sequencer_tb;
	import cis_pkg::*;

	localparam logic [3:0] CLI = 4'h8;
	localparam logic [3:0] SEI = 4'h4;
	localparam logic [3:0] RET = 4'h2;
	localparam logic [3:0] SLP = 4'h1;

	logic           sys_clk = 0;
	logic           reset_n = 0;
	logic           clkEn = 1;
	cis_cpu_in_type cpuIn = '0;
	cis_src_type    fireCmd = '0;
	cis_src_type    levelCmd = '0;
	cis_src_type    srcEvent;
	cis_src_type    srcLevel;
	logic [7:0]     stackRdata = '0;
	logic [7:0]     stackMem [0:1023];
	logic [7:0]     s_axi_awaddr = '0;
	logic [7:0]     s_axi_araddr = '0;
	logic [31:0]    s_axi_wdata = '0;
	logic [31:0]    s_axi_rdata;
	logic [3:0]     s_axi_wstrb = 4'hf;
	logic           s_axi_awvalid = 0;
	logic           s_axi_wvalid = 0;
	logic           s_axi_bready = 0;
	logic           s_axi_arvalid = 0;
	logic           s_axi_rready = 0;
	logic           s_axi_awready;
	logic           s_axi_wready;
	logic           s_axi_bvalid;
	logic           s_axi_arready;
	logic           s_axi_rvalid;
	logic [1:0]     s_axi_bresp;
	logic [1:0]     s_axi_rresp;
	logic           busy_r;
	logic           resumeValid_r;
	cis_pc_type     resumePc_r;
	cis_pc_type     pcCur;
	cis_stack_type  stack_r;
	cis_pc_type     pcQ [$];
	cis_pc_type     pcStack [$];
	logic [33:0]    rdQ [$];
	logic [15:0]    spExp = 16'h025f;
	logic [31:0]    seed = 32'h26a6;
	int             fail_count = 0;
	int             compares = 0;
	int             cycles = 0;

	cis_sequencer u_cis_sequencer (.sys_clk, .reset_n, .clkEn, .cpuIn, .srcEvent, .srcLevel,
		.stackRdata, .busy_r, .resumeValid_r, .resumePc_r, .stack_r, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);

	cis_periph_model u_cis_periph_model (.sys_clk, .reset_n, .fireCmd, .levelCmd, .srcEvent,
		.srcLevel);

	initial forever #12.5 sys_clk = ~sys_clk;

	// ==========================================================================
	// Stack memory, read data one cycle behind the address
	always @(posedge sys_clk) begin
		if (stack_r.we)
			stackMem[stack_r.addr[9:0]] <= stack_r.wdata;
		stackRdata <= stackMem[stack_r.addr[9:0]];
	end

	// ==========================================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	task automatic print_verdict();
		$display("Counts: %0d compares, %0d mismatches", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// ==========================================================================
	// Watchers: oldest note against each result
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			print_verdict();
		end
		if (resumeValid_r === 1'b1) begin
			if (pcQ.size() == 0)
				chk(resumePc_r, '1);
			else
				chk(resumePc_r, pcQ.pop_front());
		end
		if (s_axi_rvalid === 1'b1 && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, rdQ.pop_front());
	end

	// ==========================================================================
	// Bus and pipeline drivers
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = `CIS_RESP_OKAY);
		bit aw = 0;
		bit w = 0;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (!(aw && w)) begin
			@(posedge sys_clk);
			if (s_axi_awready && !aw) begin
				aw = 1;
				s_axi_awvalid <= 0;
			end
			if (s_axi_wready && !w) begin
				w = 1;
				s_axi_wvalid <= 0;
			end
		end
		do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, r);
		s_axi_bready <= 0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = `CIS_RESP_OKAY);
		@(posedge sys_clk);
		rdQ.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 0;
		do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 0;
	endtask : rd

	task automatic fire(input cis_src_type m);
		@(posedge sys_clk);
		fireCmd <= m;
		@(posedge sys_clk);
		fireCmd <= '0;
		@(posedge sys_clk);
	endtask : fire

	// One instruction boundary; returns at the edge that samples it
	task automatic instr(input logic [3:0] k);
		@(posedge sys_clk);
		pcCur = cis_pc_type'(rnd());
		cpuIn <= {1'b1, k, pcCur};
		@(posedge sys_clk);
		cpuIn.instrDone <= 0;
	endtask : instr

	task automatic waitRes(input cis_pc_type v, input int cyc);
		int n = 0;
		int b = 0;
		pcQ.push_back(v);
		while (resumeValid_r !== 1'b1 && n < 40) begin
			@(negedge sys_clk);
			n++;
			b += busy_r;
		end
		chk(n, cyc);
		chk(b, cyc - 1);
	endtask : waitRes

	task automatic takeChk(input cis_pc_type v, input int cyc);
		pcStack.push_back(pcCur);
		waitRes(v, cyc);
		chk(stackMem[spExp[9:0]], pcCur[7:0]);
		chk(stackMem[spExp[9:0] - 10'd1], {4'h0, pcCur[11:8]});
		spExp -= 16'd2;
	endtask : takeChk

	task automatic retChk();
		instr(RET);
		spExp += 16'd2;
		waitRes(pcStack.pop_back(), 5);
	endtask : retChk

	// ==========================================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1;
		rd(`CIS_OFF_STATUS, 32'h0);
		rd(`CIS_OFF_STACKPTR, 32'h25f);
		rd(8'h18, 32'h0, `CIS_RESP_SLVERR);
		wr(8'h1c, 32'hff, `CIS_RESP_SLVERR);
		$display("Test reset done");
		wr(`CIS_OFF_STATUS, 32'h80);
		fire(8'h08);
		instr(0);
		rd(`CIS_OFF_FLAGS, 32'h08);
		wr(`CIS_OFF_FLAGS, 32'h0);
		rd(`CIS_OFF_FLAGS, 32'h08);
		wr(`CIS_OFF_FLAGS, 32'h08);
		rd(`CIS_OFF_FLAGS, 32'h0);
		$display("Test flags done");
		wr(`CIS_OFF_STATUS, 32'h0);
		wr(`CIS_OFF_ENABLE, 32'hfe);
		fire(8'h24);
		instr(0);
		wr(`CIS_OFF_STATUS, 32'h81);
		instr(0);
		takeChk(2, 5);
		rd(`CIS_OFF_STATUS, 32'h01);
		rd(`CIS_OFF_FLAGS, 32'h20);
		rd(`CIS_OFF_STACKPTR, 32'h25d);
		retChk();
		rd(`CIS_OFF_STATUS, 32'h81);
		rd(`CIS_OFF_STACKPTR, 32'h25f);
		instr(0);
		instr(0);
		takeChk(5, 5);
		retChk();
		$display("Test priority done");
		instr(0);
		fire(8'h10);
		instr(CLI);
		rd(`CIS_OFF_STATUS, 32'h01);
		instr(SEI);
		instr(0);
		instr(0);
		takeChk(4, 5);
		wr(`CIS_OFF_STATUS, 32'h81);
		fire(8'h40);
		instr(0);
		takeChk(6, 5);
		retChk();
		retChk();
		$display("Test disable and nesting done");
		instr(0);
		fire(8'h80);
		instr(SLP);
		takeChk(7, 9);
		retChk();
		$display("Test sleep done");
		instr(0);
		wr(`CIS_OFF_STATUS, 32'h0);
		wr(`CIS_OFF_LEVELSEL, 32'h02);
		levelCmd <= 8'h02;
		repeat (3) @(posedge sys_clk);
		levelCmd <= 8'h00;
		wr(`CIS_OFF_STATUS, 32'h80);
		instr(0);
		levelCmd <= 8'h02;
		instr(0);
		takeChk(1, 5);
		levelCmd <= 8'h00;
		retChk();
		$display("Test level done");
		print_verdict();
	end
endmodule : cis_sequencer_tb
